// File: design/lao_pkg.sv
// Package for the literal/OR instruction execute block.
// Holds opcode patterns, field positions, reset values and state codes.
// Assumes a 14-bit instruction word and an 8-bit data path.
package lao_pkg;

  // Width of one program word.
  localparam int unsigned OP_W = 14;
  // Width of the accumulator and of each data register.
  localparam int unsigned DATA_W = 8;
  // Width of the direct register index.
  localparam int unsigned IDX_W = 7;
  // Number of data registers reachable by the direct index.
  localparam int unsigned REG_COUNT = 128;

  // The OR-literal word is 11 1000 kkkk kkkk.
  localparam logic [13:0] OR_LIT_MASK = 14'h3F00;
  localparam logic [13:0] OR_LIT_PAT = 14'h3800;
  // The load-literal word is 11 00xx kkkk kkkk; bits 9:8 are not compared.
  localparam logic [13:0] LOAD_LIT_MASK = 14'h3C00;
  localparam logic [13:0] LOAD_LIT_PAT = 14'h3000;
  // The OR-with-register word is 00 0100 dfff ffff.
  localparam logic [13:0] OR_REG_MASK = 14'h3F00;
  localparam logic [13:0] OR_REG_PAT = 14'h0400;

  // Field positions inside the word.
  localparam int unsigned LIT_LSB = 0;
  localparam int unsigned IDX_LSB = 0;
  localparam int unsigned TARGET_BIT = 7;

  // Reset values.
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [13:0] OP_RESET = 14'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Clocks that one instruction cycle spans: take, then execute.
  localparam int unsigned INSTR_CLKS = 2;

  // One-hot sequencer states.
  typedef enum logic [1:0] {
    LAO_IDLE = 2'b01,
    LAO_EXEC = 2'b10
  } lao_state_t;

endpackage

// File: design/lao_regfile.sv
// Data register file for the literal/OR execute block.
// Assumes one clock; read data is registered, so it appears one edge after the address.
module lao_regfile #(
  parameter int unsigned DEPTH = lao_pkg::REG_COUNT,
  parameter int unsigned WIDTH = lao_pkg::DATA_W,
  parameter int unsigned AW = lao_pkg::IDX_W
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // Storage array; no reset, as in a real register file.
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port, one word per edge when enabled.
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read; a write to the same word in the same edge returns the old value.
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// File: design/lao_exec.sv
// Execute unit for three single-word instructions of an 8-bit core.
// Assumes the fetch stage offers one opcode at a time and waits for ready.
module lao_exec (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Opcode from fetch, taken when op_valid and ready are both high.
  input wire logic op_valid,
  input wire logic [13:0] opcode,
  // Preload port for the data registers, used by the rest of the core.
  input wire logic load_en,
  input wire logic [6:0] load_index,
  input wire logic [7:0] load_data,
  // Status and results, all straight from flip-flops.
  output logic ready_q,
  output logic done_q,
  output logic [7:0] acc_q,
  output logic zero_q,
  output logic reg_wr_en_q,
  output logic [6:0] reg_wr_index_q,
  output logic [7:0] reg_wr_data_q
);

  // Sequencer state.
  lao_pkg::lao_state_t state_q;
  lao_pkg::lao_state_t state_d;
  // Opcode latched at the take edge.
  logic [13:0] op_q;
  // Register read data, one edge after the take.
  logic [7:0] reg_rd_data;

  // A word is taken when fetch offers one and the unit is idle.
  logic taken;
  assign taken = op_valid && ready_q;

  // Pattern match of one word; shared by the take-edge and execute decodes.
  function automatic logic op_match(input logic [13:0] op, input logic [13:0] mask,
                                    input logic [13:0] pat);
    return (op & mask) == pat;
  endfunction

  // Decode of the incoming word, used only for checks on the take edge.
  logic in_or_lit;
  logic in_load_lit;
  logic in_or_reg;
  assign in_or_lit = op_match(opcode, lao_pkg::OR_LIT_MASK, lao_pkg::OR_LIT_PAT);
  // The mask leaves bits 9:8 out, so any value there still decodes.
  assign in_load_lit = op_match(opcode, lao_pkg::LOAD_LIT_MASK, lao_pkg::LOAD_LIT_PAT);
  assign in_or_reg = op_match(opcode, lao_pkg::OR_REG_MASK, lao_pkg::OR_REG_PAT);

  // Decode of the latched word, which drives execution.
  logic is_or_lit;
  logic is_load_lit;
  logic is_or_reg;
  assign is_or_lit = op_match(op_q, lao_pkg::OR_LIT_MASK, lao_pkg::OR_LIT_PAT);
  assign is_load_lit = op_match(op_q, lao_pkg::LOAD_LIT_MASK, lao_pkg::LOAD_LIT_PAT);
  assign is_or_reg = op_match(op_q, lao_pkg::OR_REG_MASK, lao_pkg::OR_REG_PAT);

  // Operand fields of the latched word.
  logic [7:0] lit;
  logic [6:0] idx;
  logic target_reg;
  assign lit = op_q[lao_pkg::LIT_LSB +: 8];
  assign idx = op_q[lao_pkg::IDX_LSB +: 7];
  assign target_reg = op_q[lao_pkg::TARGET_BIT];

  // The OR result for both OR forms.
  logic [7:0] or_lit_res;
  logic [7:0] or_reg_res;
  assign or_lit_res = acc_q | lit;
  assign or_reg_res = acc_q | reg_rd_data;

  // Execute-cycle qualifier.
  logic exec;
  assign exec = state_q == lao_pkg::LAO_EXEC;

  // Next accumulator: only literal forms and the OR form with target zero write it.
  logic [7:0] acc_d;
  assign acc_d = !exec ? acc_q :
                 is_or_lit ? or_lit_res :
                 is_load_lit ? lit :
                 (is_or_reg && !target_reg) ? or_reg_res :
                 acc_q;

  // Next zero flag: load-literal leaves it alone; both OR forms test the result.
  logic zero_d;
  assign zero_d = !exec ? zero_q :
                  is_or_lit ? (or_lit_res == lao_pkg::ZERO_BYTE) :
                  is_or_reg ? (or_reg_res == lao_pkg::ZERO_BYTE) :
                  zero_q;

  // Register write-back for the OR form with target one.
  logic exec_wr;
  assign exec_wr = exec && is_or_reg && target_reg;

  // The write port serves write-back first; a preload in that edge is dropped.
  // Write-back is rare and one edge long, so a plain priority beats a queue.
  logic mem_wr_en;
  logic [6:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  assign mem_wr_en = exec_wr || load_en;
  assign mem_wr_addr = exec_wr ? idx : load_index;
  assign mem_wr_data = exec_wr ? or_reg_res : load_data;

  // Read address follows the incoming word so the data is ready for execute.
  logic [6:0] mem_rd_addr;
  assign mem_rd_addr = opcode[lao_pkg::IDX_LSB +: 7];

  // Data register file with a registered read port.
  lao_regfile #(
    .DEPTH(lao_pkg::REG_COUNT),
    .WIDTH(lao_pkg::DATA_W),
    .AW(lao_pkg::IDX_W)
  ) u_regfile (
    .ref_clk(ref_clk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(reg_rd_data)
  );

  // Sequencer: take in idle, execute in the next edge, then back to idle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      // Idle waits for a word from fetch.
      lao_pkg::LAO_IDLE: begin
        if (taken) begin
          state_d = lao_pkg::LAO_EXEC;
        end
      end
      // Execute always finishes in one edge.
      lao_pkg::LAO_EXEC: begin
        state_d = lao_pkg::LAO_IDLE;
      end
      // Any broken code recovers to idle.
      default: begin
        state_d = lao_pkg::LAO_IDLE;
      end
    endcase
  end

  // State, handshake and latched word.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= lao_pkg::LAO_IDLE;
      ready_q <= 1'b1;
      done_q <= 1'b0;
      op_q <= lao_pkg::OP_RESET;
    end else begin
      state_q <= state_d;
      ready_q <= state_d == lao_pkg::LAO_IDLE;
      done_q <= exec;
      op_q <= taken ? opcode : op_q;
    end
  end

  // Architectural results.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= lao_pkg::ACC_RESET;
      zero_q <= lao_pkg::ZERO_RESET;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
    end
  end

  // Registered copy of the write-back, for the rest of the core to observe.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_wr_en_q <= 1'b0;
      reg_wr_index_q <= 7'h00;
      reg_wr_data_q <= lao_pkg::ZERO_BYTE;
    end else begin
      reg_wr_en_q <= exec_wr;
      reg_wr_index_q <= exec_wr ? idx : reg_wr_index_q;
      reg_wr_data_q <= exec_wr ? or_reg_res : reg_wr_data_q;
    end
  end

  // OR literal lands in the accumulator two edges after the take.
  property p_or_lit;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && in_or_lit) |=> ##1
      (acc_q == ($past(acc_q, 2) | $past(opcode[7:0], 2))) &&
      (zero_q == (acc_q == 8'h00));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("OR literal result wrong");

  // Load literal copies the byte and keeps the zero flag.
  property p_load_lit;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && in_load_lit) |=> ##1
      (acc_q == $past(opcode[7:0], 2)) && (zero_q == $past(zero_q, 2));
  endproperty
  a_load_lit: assert property (p_load_lit) else $error("load literal wrong");

  // Every 11 00xx word is decoded as a load literal.
  property p_dont_care;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && (opcode[13:10] == 4'hC)) |=> ##1 (acc_q == $past(opcode[7:0], 2));
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("don't-care bits decoded");

  // OR with register sets the zero flag from the OR of old accumulator and read data.
  property p_or_reg_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && in_or_reg) |=> ##1
      (zero_q == (($past(acc_q, 2) | $past(reg_rd_data)) == 8'h00));
  endproperty
  a_or_reg_zero: assert property (p_or_reg_zero) else $error("OR register zero wrong");

  // Target zero: accumulator takes the result, no write-back.
  property p_target_acc;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && in_or_reg && !opcode[7]) |=> ##1
      (acc_q == ($past(acc_q, 2) | $past(reg_rd_data))) && !reg_wr_en_q;
  endproperty
  a_target_acc: assert property (p_target_acc) else $error("target zero wrong");

  // Target one: register written with the result, accumulator kept.
  property p_target_reg;
    @(posedge ref_clk) disable iff (!rst_n)
    (taken && in_or_reg && opcode[7]) |=> ##1
      reg_wr_en_q && (reg_wr_index_q == $past(opcode[6:0], 2)) &&
      (reg_wr_data_q == ($past(acc_q, 2) | $past(reg_rd_data))) &&
      (acc_q == $past(acc_q, 2));
  endproperty
  a_target_reg: assert property (p_target_reg) else $error("target one wrong");

  // Each instruction completes in exactly the instruction cycle.
  property p_one_cycle;
    @(posedge ref_clk) disable iff (!rst_n)
    taken |=> (!ready_q && !done_q) ##1 (ready_q && done_q);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction cycle length wrong");

  // Without a taken word the accumulator and flag do not move.
  property p_idle_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (ready_q && !op_valid) |=> ($stable(acc_q) && $stable(zero_q) && !reg_wr_en_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved while idle");

endmodule

// File: verif/test_literal_and_or_instr_exec.sv
// Self-checking testbench for the literal/OR execute unit, with a reference model in functions.
// Assumes lao_exec takes a word on a ready edge and answers exactly two edges later.
module test_literal_and_or_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;

  // One expected completion and the edge count at which it falls due.
  typedef struct {
    logic [7:0] acc;
    logic zero;
    logic wr;
    logic [6:0] idx;
    logic [7:0] data;
    int due;
  } lao_exp_t;

  // Every design input has a value from time zero.
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic [13:0] opcode = 14'h0000;
  logic load_en = 1'b0;
  logic [6:0] load_index = 7'h00;
  logic [7:0] load_data = 8'h00;
  logic ready_q, done_q, zero_q, reg_wr_en_q;
  logic [7:0] acc_q, reg_wr_data_q;
  logic [6:0] reg_wr_index_q;
  // Reference copies of the accumulator, the flag and the data registers.
  logic [7:0] m_acc = 8'h00;
  logic m_zero = 1'b0;
  logic [7:0] m_regs [128];
  // Completions still owed by the design, oldest first.
  lao_exp_t exp_q [$];
  lao_exp_t cur;
  int bad_count = 0;
  int samples_checked = 0;
  int edge_n = 0;

  lao_exec uut (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
    .load_en(load_en), .load_index(load_index), .load_data(load_data), .ready_q(ready_q),
    .done_q(done_q), .acc_q(acc_q), .zero_q(zero_q), .reg_wr_en_q(reg_wr_en_q),
    .reg_wr_index_q(reg_wr_index_q), .reg_wr_data_q(reg_wr_data_q));

  // Free-running 25 MHz clock.
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // Edge counter, so that completion times can be checked to the cycle.
  always @(posedge ref_clk) begin
    edge_n <= edge_n + 1;
  end

  // Counts one comparison and reports it at once if it fails.
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Works out what a taken word must leave behind and advances the model.
  function automatic lao_exp_t predict(input logic [13:0] op, input int take);
    lao_exp_t e;
    logic [7:0] res;
    e.wr = 1'b0;
    e.idx = 7'h00;
    e.data = 8'h00;
    e.due = take + int'(lao_pkg::INSTR_CLKS);
    if (op[13:8] == 6'h38) begin
      res = m_acc | op[7:0];
      m_acc = res;
      m_zero = (res == 8'h00);
    end else if (op[13:10] == 4'hC) begin
      // Bits 9:8 are ignored, so any value there must still load.
      m_acc = op[7:0];
    end else if (op[13:8] == 6'h04) begin
      res = m_acc | m_regs[op[6:0]];
      m_zero = (res == 8'h00);
      if (op[7]) begin
        e.wr = 1'b1;
        e.idx = op[6:0];
        e.data = res;
        m_regs[op[6:0]] = res;
      end else begin
        m_acc = res;
      end
    end
    e.acc = m_acc;
    e.zero = m_zero;
    return e;
  endfunction

  // Offers a word and returns on the edge that takes it; valid stays up for back-to-back use.
  task automatic issue(input logic [13:0] op);
    int n;
    n = 0;
    op_valid <= 1'b1;
    opcode <= op;
    @(posedge ref_clk);
    while (ready_q !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    // A word that was never taken owes no completion, so only a take is predicted.
    if (ready_q !== 1'b1) begin
      bad_count++;
      $display("mismatch ready expected 1 seen %b", ready_q);
    end else begin
      exp_q.push_back(predict(op, edge_n));
    end
  endtask

  // Writes one data register through the preload port; the caller must idle afterwards.
  task automatic preload(input logic [6:0] idx, input logic [7:0] d);
    load_en <= 1'b1;
    load_index <= idx;
    load_data <= d;
    m_regs[idx] = d;
    @(posedge ref_clk);
  endtask

  // Drops both requests and lets some edges pass.
  task automatic idle(input int n);
    op_valid <= 1'b0;
    load_en <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask

  // Checks each completion in the cycle it is due, and quiet outputs in every other cycle out of reset.
  always @(negedge ref_clk) begin
    if (exp_q.size() > 0 && exp_q[0].due == edge_n) begin
      cur = exp_q.pop_front();
      check("done and ready", 8'h03, {6'h00, done_q, ready_q});
      check("accumulator", cur.acc, acc_q);
      check("zero flag", {7'h00, cur.zero}, {7'h00, zero_q});
      check("write enable", {7'h00, cur.wr}, {7'h00, reg_wr_en_q});
      if (cur.wr) begin
        check("write index", {1'b0, cur.idx}, {1'b0, reg_wr_index_q});
        check("write data", cur.data, reg_wr_data_q);
      end
    end else if (rst_n) begin
      check("idle pulses", 8'h00, {6'h00, done_q, reg_wr_en_q});
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need about a fifth of this span, so a sound run ends first.
  initial begin
    #200000;
    bad_count++;
    $display("mismatch watchdog expected finish seen hang");
    complete_run();
  end

  // Main sequence: reset, fixed corner cases, then random words mixed with preloads.
  initial begin
    int k;
    logic [13:0] r;
    void'($urandom(32'h3C7DDD98));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("reset flags", 8'h80, {ready_q, done_q, zero_q, reg_wr_en_q, 4'h0});
    check("reset accumulator", 8'h00, acc_q);
    check("reset write data", 8'h00, reg_wr_data_q);
    check("reset write index", 8'h00, {1'b0, reg_wr_index_q});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    // Register contents are not reset, so every one is preloaded first.
    for (int i = 0; i < 128; i++) preload(i[6:0], 8'($urandom));
    preload(7'h05, 8'h13);
    preload(7'h00, 8'h00);
    idle(1);
    issue(14'h309A);
    issue(14'h3835);
    issue(14'h3300);
    issue(14'h3800);
    issue(14'h3191);
    issue(14'h0405);
    issue(14'h04FF);
    issue(14'h047F);
    issue(14'h3F12);
    issue(14'h3000);
    issue(14'h0480);
    // Valid stays high between words, so each word that directly follows another is offered while the unit is still busy.
    for (int i = 0; i < 300; i++) begin
      k = $urandom % 6;
      r = 14'($urandom);
      case (k)
        0: issue({6'h38, r[7:0]});
        1: issue({4'hC, r[9:0]});
        2, 3: issue({6'h04, r[7:0]});
        4: issue({6'h3F, r[7:0]});
        default: begin
          // The unit must be quiet before a preload, or a write-back could swallow it.
          idle(3);
          preload(r[6:0], r[13:6]);
          idle(1);
        end
      endcase
    end
    idle(4);
    check("owed completions", 8'h00, 8'(exp_q.size()));
    complete_run();
  end
endmodule
